// ### test/sar_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sar_link_sva (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic select_n,
  input wire logic sclk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  input wire logic track
);
  wire        oe = serial_result_oe;
  wire        dq = serial_result_out;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic       ck_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // sclk falls seen inside the current frame
  always_comb begin
    cnt_d = cnt_q;
    if (select_n)
      cnt_d = 5'h00;
    else if (ck_q && !sclk)
      cnt_d = cnt_q + 5'h01;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 5'h00;
      ck_q  <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      ck_q  <= sclk;
    end
  end
  sequence s_drive;
    ##[1:6] (oe && !dq);
  endsequence
  sequence s_early;
    !select_n [*8] ##0 cnt_q < 5'h0D;
  endsequence
  property p_start; $fell(select_n) |-> s_drive; endproperty
  property p_hold; $fell(select_n) |-> ##[1:6] !track; endproperty
  property p_idle; select_n [*8] |-> !oe; endproperty
  property p_edge;
    $changed(dq) && $past(oe) && oe |-> !$past(sclk) || !$past(sclk, 2);
  endproperty
  property p_release; cnt_q == 5'h10 |-> ##[1:6] !oe; endproperty
  property p_count; oe |-> cnt_q <= 5'h10; endproperty
  property p_track;
    $rose(track) |-> select_n || cnt_q inside {5'h0D, 5'h0E};
  endproperty
  property p_early; s_early |-> !track; endproperty
  a_start: assert property (p_start) else $error("no drive");
  a_hold: assert property (p_hold) else $error("no hold");
  a_idle: assert property (p_idle) else $error("driven idle");
  a_edge: assert property (p_edge) else $error("bad edge");
  a_release: assert property (p_release) else $error("no release");
  a_count: assert property (p_count) else $error("long frame");
  a_track: assert property (p_track) else $error("bad track");
  a_early: assert property (p_early) else $error("early track");
endmodule : sar_link_sva
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        start = 1'b0;
  logic        ready, frame_valid, s_a, s_b, b_a, b_b, ck_a, ck_b;
  logic [11:0] va = 12'h000, vb = 12'h000, ha, hb;
  logic [15:0] frame_data, wa, wb;
  int          errors = 0, n_compared = 0, i;
  sar_link_if  la ();
  sar_link_if  lb ();
  sar_device #(.TEN_BIT(1'b0)) sar_device_i (.ref_clk(ref_clk),
    .resetn(resetn), .clk_en(1'b1), .sample_value(va), .sampled(s_a),
    .held_value(ha), .busy(b_a), .link(la));
  sar_device #(.TEN_BIT(1'b1)) sar_device_ten_i (.ref_clk(ref_clk),
    .resetn(resetn), .clk_en(1'b1), .sample_value(vb), .sampled(s_b),
    .held_value(hb), .busy(b_b), .link(lb));
  sar_host sar_host_i (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
    .start(start), .ready(ready), .frame_data(frame_data),
    .frame_valid(frame_valid), .link(la));
  sar_link_sva sar_link_sva_i (.ref_clk(ref_clk), .resetn(resetn),
    .select_n(la.select_n), .sclk(la.sclk),
    .serial_result_out(la.serial_result_out),
    .serial_result_oe(la.serial_result_oe), .track(la.track));
  always #10 ref_clk = ~ref_clk;
  // line value just before each sclk fall of a frame while serial_result_oe is set
  always @(posedge ref_clk) begin
    ck_a <= la.sclk;
    ck_b <= lb.sclk;
    if (!la.select_n && la.serial_result_oe && ck_a && !la.sclk)
      wa <= {wa[14:0], la.serial_result_out};
    if (!lb.select_n && lb.serial_result_oe && ck_b && !lb.sclk)
      wb <= {wb[14:0], lb.serial_result_out};
  end
  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic host_frame(input logic [11:0] v);
    int k;
    for (k = 0; k < 99 && ready !== 1'b1; k++) @(posedge ref_clk) #1;
    check("ready", 16'(ready), 16'h0001);
    va = v;
    start = 1'b1;
    @(posedge ref_clk) #1;
    start = 1'b0;
    for (k = 0; k < 400 && frame_valid !== 1'b1; k++) @(posedge ref_clk) #1;
    check("valid", 16'(frame_valid), 16'h0001);
    check("frame", frame_data, {4'h0, v});
    check("wire_a", wa, {4'h0, v});
    check("held", {4'h0, ha}, {4'h0, v});
  endtask : host_frame
  task automatic ten_frame(input logic [11:0] v, input int n);
    @(posedge ref_clk) #1;
    vb = v;
    #6 lb.sclk = 1'b0;
    #80 lb.sclk = 1'b1;
    #80 lb.select_n = 1'b0;
    repeat (n) begin
      #80 lb.sclk = 1'b0;
      #80 lb.sclk = 1'b1;
    end
    #80 lb.select_n = 1'b1;
    #400;
    check("oe_b", 16'(lb.serial_result_oe), 16'h0000);
    check("track_b", 16'(lb.track), 16'h0001);
    if (n > 15) check("wire_b", wb, {4'h0, v[11:2], 2'h0});
  endtask : ten_frame
  initial begin
    i = $urandom(32'h6CAF);
    lb.select_n = 1'b1;
    lb.sclk = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 resetn = 1'b1;
    host_frame(12'h000);
    host_frame(12'hFFF);
    for (i = 0; i < 6; i++) host_frame(12'($urandom()));
    ten_frame(12'hFFF, 18);
    ten_frame(12'($urandom()), 8);
    ten_frame(12'($urandom()), 18);
    close_out();
  end
  initial begin
    #300000;
    errors++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire

// ### verilog/sar_device.sv
`timescale 1ns/1ps
`default_nettype none
module sar_device #(
  parameter bit TEN_BIT = 1'b0
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [11:0] sample_value,
  output logic             sampled,
  output logic [11:0]      held_value,
  output logic             busy,
  sar_link_if.dev          link
);
  typedef enum logic [1:0] {
    SAR_IDLE_S = 2'b01,
    SAR_CONV_S = 2'b10
  } sar_state_type;

  logic [1:0]  cs_sync_q, ck_sync_q;
  logic        cs_old_q, ck_old_q;
  logic        cs_fall, cs_rise, ck_fall, ck_rise;
  sar_state_type st_q, st_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [15:0] shift_q, shift_d;
  logic        dout_q, dout_d, oe_q, oe_d, trk_q, trk_d;
  logic [11:0] held_q, held_d;
  logic        smp_d, smp_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cs_sync_q <= 2'b11;
      ck_sync_q <= 2'b00;
      cs_old_q  <= 1'b1;
      ck_old_q  <= 1'b0;
    end else if (clk_en) begin
      cs_sync_q <= {cs_sync_q[0], link.select_n};
      ck_sync_q <= {ck_sync_q[0], link.sclk};
      cs_old_q  <= cs_sync_q[1];
      ck_old_q  <= ck_sync_q[1];
    end
  end

  assign cs_fall = cs_old_q & ~cs_sync_q[1];
  assign cs_rise = ~cs_old_q & cs_sync_q[1];
  assign ck_fall = ck_old_q & ~ck_sync_q[1];
  assign ck_rise = ~ck_old_q & ck_sync_q[1];

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    dout_d  = dout_q;
    oe_d    = oe_q;
    trk_d   = trk_q;
    held_d  = held_q;
    smp_d   = 1'b0;
    case (st_q)
      SAR_IDLE_S: begin
        oe_d = 1'b0;
        if (cs_fall) begin
          st_d   = SAR_CONV_S;
          cnt_d  = sar_pkg::CNT_RESET;
          trk_d  = 1'b0;
          held_d = sample_value;
          smp_d  = 1'b1;
          oe_d   = 1'b1;
          dout_d = 1'b0;
          if (TEN_BIT) begin
            shift_d = {4'h0, sample_value[11:2], 2'h0};
          end else begin
            shift_d = {4'h0, sample_value};
          end
        end
      end
      SAR_CONV_S: begin
        if (cs_rise) begin
          st_d = SAR_IDLE_S;
          oe_d = 1'b0;
          trk_d = 1'b1;
        end else begin
          if (ck_rise && cnt_q >= 5'(sar_pkg::HOLD_EDGES)) begin
            trk_d = 1'b1;
          end
          if (ck_fall) begin
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'(sar_pkg::LAST_EDGE)) begin
              oe_d = 1'b0;
              st_d = SAR_IDLE_S;
            end else begin
              dout_d  = shift_q[14];
              shift_d = {shift_q[14:0], 1'b0};
            end
          end
        end
      end
      default: begin
        st_d = SAR_IDLE_S;
        oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q    <= SAR_IDLE_S;
      cnt_q   <= sar_pkg::CNT_RESET;
      shift_q <= 16'h0000;
      dout_q  <= 1'b0;
      oe_q    <= 1'b0;
      trk_q   <= 1'b1;
      held_q  <= 12'h000;
      smp_q   <= 1'b0;
    end else if (clk_en) begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      dout_q  <= dout_d;
      oe_q    <= oe_d;
      trk_q   <= trk_d;
      held_q  <= held_d;
      smp_q   <= smp_d;
    end
  end

  assign link.serial_result_out = dout_q;
  assign link.serial_result_oe  = oe_q;
  assign link.track             = trk_q;
  assign sampled                = smp_q;
  assign held_value             = held_q;
  assign busy                   = (st_q == SAR_CONV_S);
endmodule : sar_device
`default_nettype wire

// ### verilog/sar_host.sv
`timescale 1ns/1ps
`default_nettype none
module sar_host (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        start,
  output logic             ready,
  output logic [15:0]      frame_data,
  output logic             frame_valid,
  sar_link_if.host         link
);
  typedef enum logic [2:0] {
    HST_IDLE_S = 3'b001,
    HST_RUN_S  = 3'b010,
    HST_WAIT_S = 3'b100
  } hst_state_type;

  logic [1:0]  d_sync_q;
  hst_state_type st_q, st_d;
  logic        cs_q, cs_d, ck_q, ck_d, fv_q, fv_d;
  logic [2:0]  div_q, div_d;
  logic [4:0]  edge_q, edge_d;
  logic [4:0]  gap_q, gap_d;
  logic [15:0] sh_q, sh_d;
  logic [15:0] fd_q, fd_d;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      d_sync_q <= 2'b00;
    end else if (clk_en) begin
      d_sync_q <= {d_sync_q[0], link.serial_result_out};
    end
  end

  always_comb begin
    st_d   = st_q;
    cs_d   = cs_q;
    ck_d   = ck_q;
    div_d  = div_q;
    edge_d = edge_q;
    gap_d  = gap_q;
    sh_d   = sh_q;
    fd_d   = fd_q;
    fv_d   = 1'b0;
    case (st_q)
      HST_IDLE_S: begin
        if (start) begin
          st_d   = HST_RUN_S;
          cs_d   = 1'b0;
          ck_d   = 1'b1;
          div_d  = 3'h0;
          edge_d = 5'h00;
        end
      end
      HST_RUN_S: begin
        div_d = div_q + 3'h1;
        if (div_q == 3'(sar_pkg::SCLK_HALF_CYC - 1)) begin
          div_d = 3'h0;
          ck_d  = ~ck_q;
          if (!ck_q) begin
            // rising edge k: synced line shows the bit left by fall k-1
            if (edge_q <= 5'(sar_pkg::FRAME_BITS)) begin
              sh_d = {sh_q[14:0], d_sync_q[1]};
            end
          end else begin
            edge_d = edge_q + 5'h01;
            if (edge_q == 5'(sar_pkg::BURST_CLOCKS - 1)) begin
              st_d  = HST_WAIT_S;
              cs_d  = 1'b1;
              ck_d  = 1'b1;
              gap_d = 5'h00;
              fd_d  = sh_q;
              fv_d  = 1'b1;
            end
          end
        end
        if (edge_q == 5'h00 && ck_q && div_q == 3'h0) begin
          sh_d = 16'h0000;
        end
      end
      HST_WAIT_S: begin
        gap_d = gap_q + 5'h01;
        if (gap_q == 5'(sar_pkg::ACQUIRE_CYC)) begin
          st_d = HST_IDLE_S;
        end
      end
      default: begin
        st_d = HST_IDLE_S;
        cs_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q   <= HST_IDLE_S;
      cs_q   <= 1'b1;
      ck_q   <= 1'b1;
      div_q  <= 3'h0;
      edge_q <= 5'h00;
      gap_q  <= 5'h00;
      sh_q   <= 16'h0000;
      fd_q   <= 16'h0000;
      fv_q   <= 1'b0;
    end else if (clk_en) begin
      st_q   <= st_d;
      cs_q   <= cs_d;
      ck_q   <= ck_d;
      div_q  <= div_d;
      edge_q <= edge_d;
      gap_q  <= gap_d;
      sh_q   <= sh_d;
      fd_q   <= fd_d;
      fv_q   <= fv_d;
    end
  end

  assign link.select_n = cs_q;
  assign link.sclk     = ck_q;
  assign ready         = (st_q == HST_IDLE_S);
  assign frame_data    = fd_q;
  assign frame_valid   = fv_q;
endmodule : sar_host
`default_nettype wire

// ### verilog/sar_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
  logic select_n;
  logic sclk;
  logic serial_result_out;
  logic serial_result_oe;
  logic track;
  modport dev  (input select_n, input sclk,
                output serial_result_out, output serial_result_oe,
                output track);
  modport host (output select_n, output sclk,
                input serial_result_out, input serial_result_oe);
endinterface : sar_link_if
`default_nettype wire

// ### verilog/sar_pkg.sv
package sar_pkg;
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned HOLD_EDGES    = 13;
  localparam int unsigned LAST_EDGE     = 15;
  localparam int unsigned LEAD_ZEROS    = 4;
  localparam int unsigned RES12_BITS    = 12;
  localparam int unsigned RES10_BITS    = 10;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // host timing, then the device counter reset value
  localparam int unsigned QUIET_NS      = 60;
  localparam int unsigned ACQUIRE_NS    = 290;
  localparam int unsigned QUIET_CYC     =
    (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACQUIRE_CYC   =
    (ACQUIRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BURST_CLOCKS  = 18;
  localparam int unsigned SCLK_HALF_CYC = 4;
  localparam logic [4:0]  CNT_RESET     = 5'h00;
endpackage : sar_pkg
